/* design/embedded_ram_block.sv */
// Purpose: True dual-port embedded RAM with configurable output behaviour
// Assumes: One clock mclk; both ports run on it; write collisions are user error
// Notes:   Array contents are set by INIT parameter and untouched by reset
// How it works
// - Each array bit has a configured power-on value of zero or one
// - Locations without supplied initial content power up as zero
// - Several initial words from one address fill ascending addresses
// - Word width parameter sets array word and data port widths
// - Pipeline option adds or removes a registered read output stage
// - Reset timing option makes memory reset synchronous or asynchronous
// - Three-bit chip select extends the address for up to eight blocks
// - Block answers only when chip select equals its match value
// - Each port (A/B, or write/read) has its own match value
// - Normal policy holds the read output during a write
// - Pass-new-data policy drives the written word onto the output
// - Show-old-data policy shows prior contents; only 9, 18, 36 bits
// - Write policy chosen independently for port A and port B
// - Option decides whether global set/reset affects the block
`timescale 1ns/100ps
module embedded_ram_block #(
   parameter int                                   WIDTH               = ram_cfg_pkg::DEFAULT_WIDTH,
   parameter int                                   ADDR_WIDTH          = ram_cfg_pkg::DEFAULT_ADDR_WIDTH,
   parameter int                                   DEPTH               = 1 << ADDR_WIDTH,
   parameter logic [DEPTH*WIDTH-1:0]               INIT                = '0,
   parameter int                                   INIT_BASE           = 0,
   parameter int                                   INIT_COUNT          = 0,
   parameter ram_cfg_pkg::output_pipeline_select_e output_pipeline_select = ram_cfg_pkg::unregistered_output,
   parameter ram_cfg_pkg::reset_timing_select_e    reset_timing_select = ram_cfg_pkg::reset_sync,
   parameter logic [2:0]                           port_a_select_match = ram_cfg_pkg::SELECT_MATCH_RESET,
   parameter logic [2:0]                           port_b_select_match = ram_cfg_pkg::SELECT_MATCH_RESET,
   parameter ram_cfg_pkg::write_output_policy_e    port_a_write_policy = ram_cfg_pkg::normal_hold,
   parameter ram_cfg_pkg::write_output_policy_e    port_b_write_policy = ram_cfg_pkg::normal_hold,
   parameter logic                                 global_set_reset_enable = 1'b1
) (
   input  wire logic                   mclk,
   input  wire logic                   resetn,
   input  wire logic                   global_set_reset_n,
   input  wire logic                   mem_reset,
   input  wire ram_cfg_pkg::port_ctrl_s ctrl_a,
   input  wire logic [ADDR_WIDTH-1:0]  addr_a,
   input  wire logic [WIDTH-1:0]       wdata_a,
   output      logic [WIDTH-1:0]       rdata_a,
   input  wire ram_cfg_pkg::port_ctrl_s ctrl_b,
   input  wire logic [ADDR_WIDTH-1:0]  addr_b,
   input  wire logic [WIDTH-1:0]       wdata_b,
   output      logic [WIDTH-1:0]       rdata_b
);

   // Show-old-data is legal only at widths with parity lanes
   function automatic logic old_data_ok(input int w);
      return (w == ram_cfg_pkg::OLD_DATA_WIDTH_A) || (w == ram_cfg_pkg::OLD_DATA_WIDTH_B) ||
             (w == ram_cfg_pkg::OLD_DATA_WIDTH_C);
   endfunction

   // Falls back to normal_hold when the width cannot show old data
   function automatic ram_cfg_pkg::write_output_policy_e eff_policy(input ram_cfg_pkg::write_output_policy_e p);
      if (p == ram_cfg_pkg::show_old_data && !old_data_ok(WIDTH)) begin
         return ram_cfg_pkg::normal_hold;
      end
      return p;
   endfunction

   // Init word for one address; words outside the loaded span are zero
   function automatic logic [WIDTH-1:0] init_word(input int idx);
      if (idx >= INIT_BASE && idx < INIT_BASE + INIT_COUNT) begin
         return INIT[(idx - INIT_BASE)*WIDTH +: WIDTH];
      end
      return '0;
   endfunction

   localparam ram_cfg_pkg::write_output_policy_e POLICY_A = eff_policy(port_a_write_policy);
   localparam ram_cfg_pkg::write_output_policy_e POLICY_B = eff_policy(port_b_write_policy);

   typedef logic [WIDTH-1:0] mem_t [DEPTH];

   // Whole power-on image, built once so only the write process drives the array
   function automatic mem_t init_array();
      mem_t img;
      for (int i = 0; i < DEPTH; i++) begin
         img[i] = init_word(i);
      end
      return img;
   endfunction

   // Array has no reset so contents survive memory reset and GLOBAL_SET_RESET_ENABLE
   mem_t mem_reg = init_array();

   wire sel_a = ctrl_a.enable && (ctrl_a.select == port_a_select_match);
   wire sel_b = ctrl_b.enable && (ctrl_b.select == port_b_select_match);
   wire wr_a  = sel_a && ctrl_a.write_enable;
   wire wr_b  = sel_b && ctrl_b.write_enable;

   wire [WIDTH-1:0] old_a = mem_reg[addr_a];
   wire [WIDTH-1:0] old_b = mem_reg[addr_b];

   // Per-port output load decision following the write policy
   function automatic logic out_load(input logic sel, input logic wr,
                                     input ram_cfg_pkg::write_output_policy_e p);
      return sel && (!wr || p != ram_cfg_pkg::normal_hold);
   endfunction

   function automatic logic [WIDTH-1:0] out_data(input logic wr, input ram_cfg_pkg::write_output_policy_e p,
                                                  input logic [WIDTH-1:0] old, input logic [WIDTH-1:0] nw);
      return (wr && p == ram_cfg_pkg::pass_new_data) ? nw : old;
   endfunction

   wire             load_a = out_load(sel_a, wr_a, POLICY_A);
   wire             load_b = out_load(sel_b, wr_b, POLICY_B);
   wire [WIDTH-1:0] next_a = out_data(wr_a, POLICY_A, old_a, wdata_a);
   wire [WIDTH-1:0] next_b = out_data(wr_b, POLICY_B, old_b, wdata_b);

   always_ff @(posedge mclk) begin
      if (wr_a) begin
         mem_reg[addr_a] <= wdata_a;
      end
      if (wr_b) begin
         mem_reg[addr_b] <= wdata_b;
      end
   end

   ram_port_out #(
      .WIDTH        (WIDTH),
      .PIPE         (output_pipeline_select),
      .RESET_TIMING (reset_timing_select),
      .GSR_ENABLE   (global_set_reset_enable)
   ) u_out_a (
      .mclk               (mclk),
      .resetn             (resetn),
      .global_set_reset_n (global_set_reset_n),
      .mem_reset          (mem_reset),
      .load               (load_a),
      .load_data          (next_a),
      .data_out           (rdata_a)
   );

   ram_port_out #(
      .WIDTH        (WIDTH),
      .PIPE         (output_pipeline_select),
      .RESET_TIMING (reset_timing_select),
      .GSR_ENABLE   (global_set_reset_enable)
   ) u_out_b (
      .mclk               (mclk),
      .resetn             (resetn),
      .global_set_reset_n (global_set_reset_n),
      .mem_reset          (mem_reset),
      .load               (load_b),
      .load_data          (next_b),
      .data_out           (rdata_b)
   );

endmodule // embedded_ram_block

/* pkg/ram_cfg_pkg.sv */
// Purpose: Shared constants and types for the configurable embedded RAM block
// Assumes: One clock domain, fabric logic drives all ports
// Notes:   Policies and modes are module parameters of the top
package ram_cfg_pkg;

   typedef enum logic [1:0] {
      unregistered_output,
      registered_output
   } output_pipeline_select_e;

   typedef enum logic [1:0] {
      reset_sync,
      reset_async
   } reset_timing_select_e;

   typedef enum logic [1:0] {
      normal_hold,
      pass_new_data,
      show_old_data
   } write_output_policy_e;

   localparam int DEFAULT_WIDTH      = 9;
   localparam int DEFAULT_ADDR_WIDTH = 10;
   localparam int SELECT_WIDTH       = 3;
   localparam logic [SELECT_WIDTH-1:0] SELECT_MATCH_RESET = 3'h0;
   localparam logic [SELECT_WIDTH-1:0] SELECT_MATCH_MAX   = 3'h7;

   // Widths that have the show_old_data policy
   localparam int OLD_DATA_WIDTH_A = 9;
   localparam int OLD_DATA_WIDTH_B = 18;
   localparam int OLD_DATA_WIDTH_C = 36;

   typedef struct packed {
      logic       enable;
      logic       write_enable;
      logic [2:0] select;
   } port_ctrl_s;

endpackage

/* design/ram_port_out.sv */
// Purpose: Read data selection and optional pipeline for one RAM port
// Assumes: Memory read data arrives unregistered from the array and is registered here
// Notes:   Reset clears only output registers, never the array
`timescale 1ns/100ps
module ram_port_out #(
   parameter int                                   WIDTH          = ram_cfg_pkg::DEFAULT_WIDTH,
   parameter ram_cfg_pkg::output_pipeline_select_e PIPE           = ram_cfg_pkg::unregistered_output,
   parameter ram_cfg_pkg::reset_timing_select_e    RESET_TIMING   = ram_cfg_pkg::reset_sync,
   parameter logic                                 GSR_ENABLE     = 1'b1
) (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic             global_set_reset_n,
   input  wire logic             mem_reset,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_data,
   output      logic [WIDTH-1:0] data_out
);

   logic [WIDTH-1:0] stage_reg;
   logic [WIDTH-1:0] pipe_reg;
   wire              gsr_hit   = GSR_ENABLE && !global_set_reset_n;
   wire              async_clr = (RESET_TIMING == ram_cfg_pkg::reset_async) && mem_reset;
   wire              arst_n    = resetn && !gsr_hit && !async_clr;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         stage_reg <= '0;
         pipe_reg  <= '0;
      end else if (mem_reset) begin
         stage_reg <= '0;
         pipe_reg  <= '0;
      end else begin
         if (load) begin
            stage_reg <= load_data;
         end
         pipe_reg <= stage_reg;
      end
   end

   assign data_out = (PIPE == ram_cfg_pkg::registered_output) ? pipe_reg : stage_reg;

endmodule // ram_port_out

/* dv/ram_block_properties.sv */
// Purpose: Port checks for the embedded RAM block
// Assumes: Sync memory reset, pass_new_data on A, show_old_data on B
// Notes:   Array contents are not visible, so checks tie reads to earlier writes
`timescale 1ns/100ps
module ram_block_properties #(
   parameter int         WIDTH      = 9,
   parameter int         ADDR_WIDTH = 4,
   parameter logic [2:0] A_SEL      = 3'h0,
   parameter logic [2:0] B_SEL      = 3'h0
) (
   input wire logic                    mclk,
   input wire logic                    resetn,
   input wire logic                    global_set_reset_n,
   input wire logic                    mem_reset,
   input wire ram_cfg_pkg::port_ctrl_s ctrl_a,
   input wire logic [ADDR_WIDTH-1:0]   addr_a,
   input wire logic [WIDTH-1:0]        wdata_a,
   input wire logic [WIDTH-1:0]        rdata_a,
   input wire ram_cfg_pkg::port_ctrl_s ctrl_b,
   input wire logic [ADDR_WIDTH-1:0]   addr_b,
   input wire logic [WIDTH-1:0]        wdata_b,
   input wire logic [WIDTH-1:0]        rdata_b
);
   wire a_req = ctrl_a.enable && ctrl_a.select == A_SEL;
   wire b_req = ctrl_b.enable && ctrl_b.select == B_SEL;
   wire a_wr  = a_req && ctrl_a.write_enable;
   wire b_wr  = b_req && ctrl_b.write_enable;
   wire quiet = !mem_reset && global_set_reset_n;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_new_data_a: assert property (a_wr |=> rdata_a == $past(wdata_a)) else $error("A write data not shown");
   a_idle_hold_a: assert property (!a_req && quiet |=> !global_set_reset_n || $stable(rdata_a))
      else $error("A output moved without request");
   a_idle_hold_b: assert property (!b_req && quiet |=> !global_set_reset_n || $stable(rdata_b))
      else $error("B output moved without request");
   a_mem_reset_clear: assert property (mem_reset |=> rdata_a == '0 && rdata_b == '0)
      else $error("Memory reset left output");
   a_gsr_clear: assert property (!global_set_reset_n |=> rdata_a == '0 && rdata_b == '0)
      else $error("Global reset left output");
   a_release_zero: assert property ($rose(resetn) |-> rdata_a == '0 && rdata_b == '0)
      else $error("Output not zero after reset");
   a_read_back_a: assert property (a_wr ##1 (a_req && !ctrl_a.write_enable && addr_a == $past(addr_a))
      |=> rdata_a == $past(wdata_a, 2)) else $error("A read back wrong");
   a_old_data_b: assert property (a_wr ##1 (b_wr && addr_b == $past(addr_a))
      |=> rdata_b == $past(wdata_a, 2)) else $error("B old data wrong");
endmodule // ram_block_properties
bind embedded_ram_block ram_block_properties #(.WIDTH(WIDTH), .ADDR_WIDTH(ADDR_WIDTH),
   .A_SEL(port_a_select_match), .B_SEL(port_b_select_match)) chk (.mclk(mclk), .resetn(resetn),
   .global_set_reset_n(global_set_reset_n), .mem_reset(mem_reset), .ctrl_a(ctrl_a), .addr_a(addr_a),
   .wdata_a(wdata_a), .rdata_a(rdata_a), .ctrl_b(ctrl_b), .addr_b(addr_b), .wdata_b(wdata_b), .rdata_b(rdata_b));

/* dv/fabric_port_b.sv */
// Purpose: Fabric-side request former for port B
// Assumes: Caller holds go for exactly one edge
// Notes:   Select comes from the bench so refused B accesses can be driven
`timescale 1ns/100ps
module fabric_port_b (
   input  wire logic                    go,
   input  wire logic                    we,
   input  wire logic [2:0]              sel,
   output      ram_cfg_pkg::port_ctrl_s ctrl
);
   assign ctrl = '{go, we, sel};
endmodule // fabric_port_b

/* dv/embedded_ram_block_tb.sv */
// Purpose: Self-checking bench for the embedded RAM block
// Assumes: Port A match 5, port B match 2, sync memory reset
// Notes:   Initial words sit at addresses 2 to 4
`timescale 1ns/100ps
module embedded_ram_block_tb;
   logic mclk, resetn, gsr_n, mem_reset, b_go, b_we;
   logic [3:0] addr_a, addr_b;
   logic [2:0] b_sel;
   logic [8:0] wdata_a, wdata_b, rdata_a, rdata_b;
   ram_cfg_pkg::port_ctrl_s ctrl_a, ctrl_b;
   int failures = 0, n_checks = 0, cyc = 0;
   embedded_ram_block #(.WIDTH(9), .ADDR_WIDTH(4), .INIT({117'h0, 9'h1a3, 9'h0f1, 9'h155}), .INIT_BASE(2),
      .INIT_COUNT(3), .port_a_select_match(3'h5), .port_b_select_match(3'h2),
      .port_a_write_policy(ram_cfg_pkg::pass_new_data), .port_b_write_policy(ram_cfg_pkg::show_old_data)) uut (
      .mclk(mclk), .resetn(resetn), .global_set_reset_n(gsr_n), .mem_reset(mem_reset), .ctrl_a(ctrl_a),
      .addr_a(addr_a), .wdata_a(wdata_a), .rdata_a(rdata_a), .ctrl_b(ctrl_b), .addr_b(addr_b),
      .wdata_b(wdata_b), .rdata_b(rdata_b));
   fabric_port_b partner (.go(b_go), .we(b_we), .sel(b_sel), .ctrl(ctrl_b));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task complete_run;
      if (failures == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task op_a(input logic we, input logic [2:0] sel, input logic [3:0] ad, input logic [8:0] d);
      @(posedge mclk);
      ctrl_a <= '{1'b1, we, sel};
      addr_a <= ad;
      wdata_a <= d;
      @(posedge mclk);
      ctrl_a <= '{1'b0, 1'b0, 3'h5};
      #1;
   endtask
   task op_b(input logic we, input logic [2:0] sel, input logic [3:0] ad, input logic [8:0] d);
      @(posedge mclk);
      {b_go, b_we, b_sel, addr_b, wdata_b} <= {1'b1, we, sel, ad, d};
      @(posedge mclk);
      b_go <= 1'b0;
      #1;
   endtask
   // Write then read the same word on consecutive edges
   task t_back;
      @(posedge mclk);
      ctrl_a <= '{1'b1, 1'b1, 3'h5};
      addr_a <= 4'h9;
      wdata_a <= 9'h12c;
      @(posedge mclk);
      ctrl_a <= '{1'b1, 1'b0, 3'h5};
      @(posedge mclk);
      ctrl_a <= '{1'b0, 1'b0, 3'h5};
      #1 chk("back to back", 9'h12c, rdata_a);
   endtask
   task t_init;
      logic [8:0] e [5];
      e = '{9'h000, 9'h155, 9'h0f1, 9'h1a3, 9'h000};
      for (int i = 0; i < 5; i++) begin
         op_a(1'b0, 3'h5, 4'(i + 1), 9'h000);
         chk("init word", e[i], rdata_a);
      end
   endtask
   task t_write;
      @(posedge mclk);
      ctrl_a <= '{1'b1, 1'b1, 3'h5};
      addr_a <= 4'h7;
      wdata_a <= 9'h1ff;
      @(posedge mclk);
      ctrl_a <= '{1'b0, 1'b0, 3'h5};
      {b_go, b_we, addr_b, wdata_b} <= {2'b11, 4'h7, 9'h0aa};
      #1 chk("rdata_a new", 9'h1ff, rdata_a);
      @(posedge mclk);
      b_go <= 1'b0;
      #1 chk("rdata_b old", 9'h1ff, rdata_b);
      op_a(1'b0, 3'h5, 4'h7, 9'h000);
      chk("read back", 9'h0aa, rdata_a);
   endtask
   task t_select;
      op_a(1'b1, 3'h2, 4'h8, 9'h0cc);
      chk("refused hold", 9'h0aa, rdata_a);
      op_a(1'b0, 3'h5, 4'h8, 9'h000);
      chk("refused write", 9'h000, rdata_a);
      op_b(1'b1, 3'h5, 4'h7, 9'h055);
      chk("b refused", 9'h1ff, rdata_b);
      op_b(1'b0, 3'h2, 4'h7, 9'h000);
      chk("b read", 9'h0aa, rdata_b);
   endtask
   task t_reset;
      @(posedge mclk) mem_reset <= 1'b1;
      @(posedge mclk) mem_reset <= 1'b0;
      #1 chk("mem reset", 9'h000, rdata_a);
      op_a(1'b0, 3'h5, 4'h3, 9'h000);
      chk("array kept", 9'h0f1, rdata_a);
      @(posedge mclk) gsr_n <= 1'b0;
      @(posedge mclk) gsr_n <= 1'b1;
      #1 chk("global reset", 9'h000, rdata_a);
   endtask
   // Ceiling is far above the few dozen cycles the sequence needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         failures++;
         complete_run;
      end
   end
   initial begin
      {resetn, gsr_n, mem_reset, b_go, b_we} = 5'b01000;
      {addr_a, addr_b, wdata_a, wdata_b} = '0;
      ctrl_a = '{1'b0, 1'b0, 3'h5};
      b_sel = 3'h2;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      t_init;
      t_write;
      t_select;
      t_back;
      t_reset;
      complete_run;
   end
endmodule // embedded_ram_block_tb
